// ---- logic/sph_regs.vh ----
// Purpose: constants of the serial/parallel host register port
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef SPH_REGS_VH
`define SPH_REGS_VH
// serial header codes
`define SPH_HDR_NI_PAIR 8'h40
`define SPH_HDR_IL_PAIR 8'h48
`define SPH_HDR_BURST 8'h43
`define SPH_HDR_NI_RDWB 8'h41
`define SPH_HDR_IL_RDWB 8'h49
// address byte layout
`define SPH_RD_FLAG_BIT 7
`define SPH_FIFO_TOP 7'h1f
`define SPH_BURST_TOP 7'h7d
// indirect mode virtual registers, selected by address bit 0
`define SPH_IND_ADDR_OFS 1'b0
`define SPH_IND_DATA_OFS 1'b1
`define SPH_IND_ADDR_RST 8'h00
// addressing-mode bit location in the mode register
`define SPH_MODE_CONFIG_TWO_ADDR 7'h3f
`define SPH_ADDR_MODE_SELECT_BIT 0
`define SPH_ADDR_MODE_SELECT_RST 1'b0
// cycles the ale pin must settle after reset before edges count
`define SPH_ALE_ARM_CNT 2'h3
`endif

// ---- logic/sph_sync.v ----
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second
`timescale 1ns/10ps
module sph_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input wire i_core_clk,
  input wire i_rstn,
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= i_d;
      sync_ff <= meta_ff;
    end
  end

  assign o_q = sync_ff;
endmodule

// ---- logic/sph_port.v ----
// Purpose: host register access port, serial control port and 8-bit parallel port
// Assumes: i_core_clk far faster than host strobes; sclk period >= 16 core cycles
// Notes: register file is outside; i_reg_rdata valid the cycle after o_reg_rd
//
// Summary of operation
// R1: serial access starts on chip select fall, ends on chip select rise.
// R2: input sampled on rising serial clock, output changed on falling edge.
// R3: serial bytes are eight bits, most significant bit first.
// R4: first byte after chip select falls is a header choosing the sequence.
// R5: header 40 gives non-interleaved address/data pairs over 00 to 7F.
// R6: in pair mode output driven only while returning read data.
// R7: header 48 returns read data while next address is shifted in.
// R8: header 43 is one address followed by many same-direction data bytes.
// R9: burst addresses 00 to 1F hit the fifo; pointer advances per byte.
// R10: bursts allowed for addresses 00 to 7D.
// R11: bursts end only when chip select rises.
// R12: header 41 reads pairs until a write address starts a write burst.
// R13: header 49 is as 41 with interleaved read phase.
// R14: address byte top bit set means read, clear means write.
// R15: parallel port mode chosen by latch strobe: high, low, or toggling.
// R16: any latch strobe edge selects multiplexed mode until hardware reset.
// R17: non-multiplexed host presents address during each data transfer.
// R18: multiplexed mode latches address from shared lines by latch strobe.
// R19: addressing-mode bit resets to indirect (0); 1 means direct.
// R20: host switches to direct mode by a write made in indirect mode.
// R21: indirect mode decodes only address bit 0: holder or data window.
// R22: indirect access writes holder first, then data window reaches target.
`timescale 1ns/10ps
`include "sph_regs.vh"
module sph_port (
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_port_serial,
  input wire i_sclk,
  input wire i_cs_n,
  input wire i_serial_data_in,
  output wire o_serial_data_out,
  output wire o_serial_data_out_oe,
  input wire i_ale,
  input wire i_wr_n,
  input wire i_data_strobe_n,
  input wire [6:0] i_addr_lines,
  input wire [7:0] i_data_lines,
  output wire [7:0] o_data_lines,
  output wire o_data_lines_oe,
  output wire o_reg_rd,
  output wire o_reg_wr,
  output wire [6:0] o_reg_addr,
  output wire [7:0] o_reg_wdata,
  input wire [7:0] i_reg_rdata,
  output wire o_fifo_adv,
  output wire o_addr_mode_select,
  output wire o_muxed_mode,
  output wire o_strobe_mode
);
  localparam S_HDR = 3'h0;
  localparam S_ADR = 3'h1;
  localparam S_RDN = 3'h2;
  localparam S_WDT = 3'h3;
  localparam S_BWR = 3'h4;
  localparam S_BRD = 3'h5;
  localparam S_IGN = 3'h6;

  wire [21:0] sync_q;
  wire sclk_s = sync_q[0];
  wire cs_s = sync_q[1];
  wire sdi_s = sync_q[2];
  wire ale_s = sync_q[3];
  wire wr_s = sync_q[4];
  wire ds_s = sync_q[5];
  wire [6:0] addr_s = sync_q[12:6];
  wire [7:0] data_s = sync_q[20:13];
  wire ser_sel_s = sync_q[21];

  // all pins cross into the core domain before any decode
  sph_sync #(.W(22), .RST_VAL(22'h3fffff)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_d({i_port_serial, i_data_lines, i_addr_lines, i_data_strobe_n, i_wr_n, i_ale,
          i_serial_data_in, i_cs_n, i_sclk}),
    .o_q(sync_q)
  );

  reg sclk_q_ff;
  reg cs_q_ff;
  reg ale_q_ff;
  reg [1:0] arm_ff;
  reg rd_done_ff;
  reg o_rd_ff;
  reg o_wr_ff;
  reg [6:0] o_addr_ff;
  reg [7:0] o_wdata_ff;
  reg o_adv_ff;
  reg addr_mode_select_ff;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sclk_q_ff <= 1'b1;
      cs_q_ff <= 1'b1;
      ale_q_ff <= 1'b1;
    end else begin
      sclk_q_ff <= sclk_s;
      cs_q_ff <= cs_s;
      ale_q_ff <= ale_s;
    end
  end

  wire ser_act = ser_sel_s & ~cs_s; // R1
  wire sclk_rise = sclk_s & ~sclk_q_ff; // R2
  wire sclk_fall = ~sclk_s & sclk_q_ff; // R2

  // serial engine
  reg [2:0] st_ff;
  reg [2:0] bit_cnt_ff;
  reg [7:0] rx_ff;
  reg [7:0] tx_ff;
  reg [7:0] hdr_ff;
  reg [6:0] sadr_ff;
  reg drive_ff;
  reg sdo_ff;
  reg sdo_oe_ff;
  reg s_rd_ff;
  reg s_wr_ff;
  reg s_adv_ff;
  reg [6:0] s_addr_ff;
  reg [7:0] s_wdata_ff;

  wire [7:0] rx_byte = {rx_ff[6:0], sdi_s}; // R3
  wire byte_done = sclk_rise & (bit_cnt_ff == 3'h7); // R3
  wire hdr_il = (hdr_ff == `SPH_HDR_IL_PAIR) | (hdr_ff == `SPH_HDR_IL_RDWB);
  wire hdr_wb = (hdr_ff == `SPH_HDR_BURST) | (hdr_ff == `SPH_HDR_NI_RDWB) | (hdr_ff == `SPH_HDR_IL_RDWB);
  wire hdr_ok = (rx_byte == `SPH_HDR_NI_PAIR) | (rx_byte == `SPH_HDR_IL_PAIR) | (rx_byte == `SPH_HDR_BURST) |
                (rx_byte == `SPH_HDR_NI_RDWB) | (rx_byte == `SPH_HDR_IL_RDWB);
  wire burst_ok = (rx_byte[6:0] <= `SPH_BURST_TOP);
  wire sadr_fifo = (sadr_ff <= `SPH_FIFO_TOP);

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= S_HDR;
      bit_cnt_ff <= 3'h0;
      rx_ff <= 8'h00;
      tx_ff <= 8'h00;
      hdr_ff <= 8'h00;
      sadr_ff <= 7'h00;
      drive_ff <= 1'b0;
      sdo_ff <= 1'b1;
      sdo_oe_ff <= 1'b0;
      s_rd_ff <= 1'b0;
      s_wr_ff <= 1'b0;
      s_adv_ff <= 1'b0;
      s_addr_ff <= 7'h00;
      s_wdata_ff <= 8'h00;
    end else begin
      s_rd_ff <= 1'b0;
      s_wr_ff <= 1'b0;
      s_adv_ff <= 1'b0;
      if (rd_done_ff && ser_sel_s) begin
        tx_ff <= i_reg_rdata;
      end
      if (!ser_act) begin
        // a chip select rise ends any sequence, bursts included
        st_ff <= S_HDR; // R1 R11
        bit_cnt_ff <= 3'h0;
        drive_ff <= 1'b0;
        sdo_oe_ff <= 1'b0;
      end else begin
        if (sclk_fall) begin
          sdo_oe_ff <= drive_ff; // R6
          if (drive_ff) begin
            sdo_ff <= tx_ff[7]; // R2 R3
            tx_ff <= {tx_ff[6:0], 1'b0};
          end
        end
        if (sclk_rise) begin
          rx_ff <= rx_byte;
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
        if (byte_done) begin
          drive_ff <= 1'b0; // R6
          case (st_ff)
            S_HDR: begin
              hdr_ff <= rx_byte; // R4
              st_ff <= hdr_ok ? S_ADR : S_IGN; // R4
            end
            S_ADR: begin
              sadr_ff <= rx_byte[6:0];
              if (rx_byte[`SPH_RD_FLAG_BIT]) begin // R14
                if (hdr_ff == `SPH_HDR_BURST) begin
                  st_ff <= burst_ok ? S_BRD : S_IGN; // R8 R10
                end else begin
                  st_ff <= hdr_il ? S_ADR : S_RDN; // R5 R7
                end
                if ((hdr_ff != `SPH_HDR_BURST) || burst_ok) begin
                  s_rd_ff <= 1'b1;
                  s_addr_ff <= rx_byte[6:0];
                  drive_ff <= 1'b1; // R5 R7
                end
              end else if (hdr_wb) begin
                st_ff <= burst_ok ? S_BWR : S_IGN; // R8 R10 R12 R13
              end else begin
                st_ff <= S_WDT; // R5
              end
            end
            S_RDN: begin
              // read byte went out; input was ignored meanwhile
              st_ff <= S_ADR; // R5
            end
            S_WDT: begin
              s_wr_ff <= 1'b1;
              s_addr_ff <= sadr_ff;
              s_wdata_ff <= rx_byte;
              st_ff <= S_ADR;
            end
            S_BWR: begin
              s_wr_ff <= 1'b1; // R8
              s_addr_ff <= sadr_ff;
              s_wdata_ff <= rx_byte;
              s_adv_ff <= sadr_fifo; // R9
            end
            S_BRD: begin
              s_rd_ff <= 1'b1; // R8
              s_addr_ff <= sadr_ff;
              s_adv_ff <= sadr_fifo; // R9
              drive_ff <= 1'b1;
            end
            S_IGN: begin
              st_ff <= S_IGN;
            end
            default: begin
              st_ff <= S_IGN;
            end
          endcase
        end
      end
    end
  end

  // parallel engine
  reg muxed_ff;
  reg acc_q_ff;
  reg prd_ff;
  reg [6:0] lat_ff;
  reg [6:0] paddr_ff;
  reg [7:0] pwd_ff;
  reg [7:0] holder_ff;
  reg [7:0] pdo_ff;
  reg pdo_oe_ff;
  reg p_rd_ff;
  reg p_wr_ff;
  reg [6:0] p_addr_ff;
  reg [7:0] p_wdata_ff;
  reg strb_ff;

  // static high ale means r/w plus data strobe, static low means rd/wr pins
  wire strobe_mode = ale_s & ~muxed_ff; // R15
  wire pcs_act = ~ser_sel_s & ~cs_s;
  wire acc = pcs_act & (strobe_mode ? ~ds_s : (~ds_s | ~wr_s)); // R15
  wire is_read = strobe_mode ? wr_s : ~ds_s;
  wire acc_start = acc & ~acc_q_ff;
  wire acc_stop = ~acc & acc_q_ff;
  wire [6:0] eff_addr = muxed_ff ? lat_ff : addr_s; // R17 R18
  wire ale_edge = (ale_s != ale_q_ff) & (arm_ff == `SPH_ALE_ARM_CNT);

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      arm_ff <= 2'h0;
      muxed_ff <= 1'b0;
      acc_q_ff <= 1'b0;
      prd_ff <= 1'b0;
      lat_ff <= 7'h00;
      paddr_ff <= 7'h00;
      pwd_ff <= 8'h00;
      holder_ff <= `SPH_IND_ADDR_RST;
      pdo_ff <= 8'h00;
      pdo_oe_ff <= 1'b0;
      p_rd_ff <= 1'b0;
      p_wr_ff <= 1'b0;
      p_addr_ff <= 7'h00;
      p_wdata_ff <= 8'h00;
      strb_ff <= 1'b1;
    end else begin
      p_rd_ff <= 1'b0;
      p_wr_ff <= 1'b0;
      strb_ff <= strobe_mode; // R15
      acc_q_ff <= acc;
      // edge watch waits for the synchroniser to hold the real pin level
      if (arm_ff != `SPH_ALE_ARM_CNT) begin
        arm_ff <= arm_ff + 2'h1;
      end
      if (ale_edge) begin
        muxed_ff <= 1'b1; // R16
      end
      if (muxed_ff && ale_q_ff && !ale_s) begin
        lat_ff <= data_s[6:0]; // R18
      end
      if (acc) begin
        pwd_ff <= data_s;
      end
      pdo_oe_ff <= acc & is_read;
      if (acc_start) begin
        prd_ff <= is_read;
        paddr_ff <= eff_addr;
        if (is_read) begin
          if (addr_mode_select_ff) begin
            p_rd_ff <= 1'b1;
            p_addr_ff <= eff_addr;
          end else if (eff_addr[0] == `SPH_IND_ADDR_OFS) begin // R21
            pdo_ff <= holder_ff;
          end else begin
            p_rd_ff <= 1'b1; // R22
            p_addr_ff <= holder_ff[6:0];
          end
        end
      end
      if (rd_done_ff && !ser_sel_s) begin
        pdo_ff <= i_reg_rdata;
      end
      // writes commit at strobe end, when data has settled
      if (acc_stop && !prd_ff) begin
        if (addr_mode_select_ff) begin
          p_wr_ff <= 1'b1;
          p_addr_ff <= paddr_ff;
          p_wdata_ff <= pwd_ff;
        end else if (paddr_ff[0] == `SPH_IND_ADDR_OFS) begin // R21
          holder_ff <= pwd_ff; // R22
        end else begin
          p_wr_ff <= 1'b1; // R22
          p_addr_ff <= holder_ff[6:0];
          p_wdata_ff <= pwd_ff;
        end
      end
    end
  end

  // shared request stage toward the register file
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_ff <= 1'b0;
      o_wr_ff <= 1'b0;
      o_addr_ff <= 7'h00;
      o_wdata_ff <= 8'h00;
      o_adv_ff <= 1'b0;
      rd_done_ff <= 1'b0;
      addr_mode_select_ff <= `SPH_ADDR_MODE_SELECT_RST; // R19
    end else begin
      o_rd_ff <= ser_sel_s ? s_rd_ff : p_rd_ff;
      o_wr_ff <= ser_sel_s ? s_wr_ff : p_wr_ff;
      o_addr_ff <= ser_sel_s ? s_addr_ff : p_addr_ff;
      o_wdata_ff <= ser_sel_s ? s_wdata_ff : p_wdata_ff;
      o_adv_ff <= ser_sel_s & s_adv_ff;
      rd_done_ff <= o_rd_ff;
      // mode bit follows any write to its register, from either port
      if (o_wr_ff && (o_addr_ff == `SPH_MODE_CONFIG_TWO_ADDR)) begin
        addr_mode_select_ff <= o_wdata_ff[`SPH_ADDR_MODE_SELECT_BIT]; // R19 R20
      end
    end
  end

  assign o_serial_data_out = sdo_ff;
  assign o_serial_data_out_oe = sdo_oe_ff;
  assign o_data_lines = pdo_ff;
  assign o_data_lines_oe = pdo_oe_ff;
  assign o_reg_rd = o_rd_ff;
  assign o_reg_wr = o_wr_ff;
  assign o_reg_addr = o_addr_ff;
  assign o_reg_wdata = o_wdata_ff;
  assign o_fifo_adv = o_adv_ff;
  assign o_addr_mode_select = addr_mode_select_ff;
  assign o_muxed_mode = muxed_ff;
  assign o_strobe_mode = strb_ff;
endmodule

// ---- testbench/sph_port_chk.sv ----
// Purpose: assertions on the host register port
// Assumes: one core clock domain, async active-low reset
// Notes: bound to sph_port below
`timescale 1ns/10ps
module sph_port_chk (
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_port_serial,
  input wire i_sclk,
  input wire i_cs_n,
  input wire o_serial_data_out,
  input wire o_serial_data_out_oe,
  input wire o_reg_rd,
  input wire o_reg_wr,
  input wire [6:0] o_reg_addr,
  input wire o_fifo_adv,
  input wire o_addr_mode_select,
  input wire o_muxed_mode
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  a_rd_one_cycle: assert property (o_reg_rd |=> !o_reg_rd) else $error("read pulse too long");
  a_wr_one_cycle: assert property (o_reg_wr |=> !o_reg_wr) else $error("write pulse too long");
  a_fifo_with_req: assert property (o_fifo_adv |-> (o_reg_rd || o_reg_wr) && o_reg_addr <= 7'h1f)
    else $error("fifo advance outside a low burst request");
  a_mux_sticky: assert property (o_muxed_mode |=> o_muxed_mode) else $error("mux mode lost");
  a_addr_mode_select_after_rst: assert property ($rose(i_rstn) |-> !o_addr_mode_select) else $error("not indirect");
  a_sdo_on_fall: assert property ($changed(o_serial_data_out) && o_serial_data_out_oe |-> !i_sclk)
    else $error("serial output moved while clock high");
  a_oe_idle_cs: assert property (i_cs_n [*8] |-> !o_serial_data_out_oe) else $error("output driven idle");
  a_par_quiet_sdo: assert property (!i_port_serial |-> !o_serial_data_out_oe)
    else $error("serial output driven in parallel mode");
endmodule
bind sph_port sph_port_chk sph_port_chk_i (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
  .i_port_serial(i_port_serial), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_serial_data_out(o_serial_data_out),
  .o_serial_data_out_oe(o_serial_data_out_oe), .o_reg_rd(o_reg_rd), .o_reg_wr(o_reg_wr),
  .o_reg_addr(o_reg_addr), .o_fifo_adv(o_fifo_adv), .o_addr_mode_select(o_addr_mode_select),
  .o_muxed_mode(o_muxed_mode));

// ---- testbench/sph_host_model.sv ----
// Purpose: host microcontroller on the serial and parallel buses
// Assumes: sclk half period 10 core cycles, idle low
// Notes: released serial line reads as pull-up high
`timescale 1ns/10ps
module sph_host_model (
  input wire i_core_clk,
  input wire i_sdo,
  input wire i_sdo_oe,
  input wire [7:0] i_dl,
  input wire i_dl_oe,
  output reg o_sclk,
  output reg o_cs_n,
  output reg o_sdi,
  output reg o_ale,
  output reg o_wr_n,
  output reg o_ds_n,
  output reg [6:0] o_addr,
  output reg [7:0] o_data
);
  wire line = i_sdo_oe ? i_sdo : 1'b1;
  initial begin
    {o_sclk, o_ale} = 2'b00;
    {o_cs_n, o_sdi, o_wr_n, o_ds_n} = 4'hf;
    o_addr = 7'h7f;
    o_data = 8'hff;
  end
  task wt(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task cs_set(input logic v);
    wt(10);
    o_cs_n <= v;
    wt(20);
  endtask
  // byte sent msb first; data set while clock low, sampled at rise
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sdi <= tx[i];
      wt(10);
      rx[i] = line;
      o_sclk <= 1'b1;
      wt(10);
      o_sclk <= 1'b0;
    end
  endtask
  // address held through the whole strobe
  task par(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    o_addr <= a;
    o_data <= d;
    o_cs_n <= 1'b0;
    o_wr_n <= !w;
    // ale held high means the r/w plus data strobe bus
    o_ds_n <= w & !o_ale;
    wt(12);
    q = i_dl_oe ? i_dl : 8'hff;
    {o_cs_n, o_wr_n, o_ds_n} <= 3'h7;
    wt(12);
  endtask
  task ale_edge;
    o_ale <= !o_ale;
    wt(8);
  endtask
  // address on the shared lines, taken by the ale fall
  task mux_addr(input logic [6:0] a);
    o_data <= {1'b0, a};
    o_ale <= 1'b1;
    wt(8);
    o_ale <= 1'b0;
    wt(8);
  endtask
endmodule

// ---- testbench/sph_port_tb.sv ----
// Purpose: self-checking bench of the host register port
// Assumes: register file answers addr xor 5a, combinationally
// Notes: serial scenarios first, then parallel and strobe bus after further resets
`timescale 1ns/10ps
module sph_port_tb;
  logic clk, rstn, ser;
  wire sclk, cs_n, sdi, sdo, sdo_oe, ale, wr_n, ds_n, dl_oe, rd, wr, adv, addr_mode_select, mux, strb;
  wire [6:0] al, ra;
  wire [7:0] dli, dlo, wdat;
  wire [7:0] rdat = {1'b0, ra} ^ 8'h5a;
  logic [7:0] rx, q, nw = 0, nf = 0, s_w, s_f;
  logic [6:0] wa;
  logic [7:0] wd;
  int n_mismatch = 0, total_checks = 0;
  initial begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end
  always @(posedge clk) begin
    if (wr) begin
      wa <= ra;
      wd <= wdat;
      nw <= nw + 8'h01;
    end
    if (adv) nf <= nf + 8'h01;
  end
  sph_port sph_port_i (.i_core_clk(clk), .i_rstn(rstn), .i_port_serial(ser), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_serial_data_in(sdi), .o_serial_data_out(sdo), .o_serial_data_out_oe(sdo_oe), .i_ale(ale),
    .i_wr_n(wr_n), .i_data_strobe_n(ds_n), .i_addr_lines(al), .i_data_lines(dli), .o_data_lines(dlo),
    .o_data_lines_oe(dl_oe), .o_reg_rd(rd), .o_reg_wr(wr), .o_reg_addr(ra), .o_reg_wdata(wdat),
    .i_reg_rdata(rdat), .o_fifo_adv(adv), .o_addr_mode_select(addr_mode_select), .o_muxed_mode(mux),
    .o_strobe_mode(strb));
  sph_host_model sph_host_model_i (.i_core_clk(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe), .i_dl(dlo),
    .i_dl_oe(dl_oe), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .o_ale(ale), .o_wr_n(wr_n),
    .o_ds_n(ds_n), .o_addr(al), .o_data(dli));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("mismatches=%0d checks=%0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task do_reset(input logic s, input logic a);
    rstn <= 1'b0;
    ser <= s;
    sph_host_model_i.wt(5);
    // ale level set while reset holds, so no edge is seen after
    if (sph_host_model_i.o_ale != a) sph_host_model_i.ale_edge();
    rstn <= 1'b1;
    sph_host_model_i.wt(8);
    chk({3'h0, sdo_oe, dl_oe, rd, wr, addr_mode_select}, 8'h00);
  endtask
  task t_hdr40;
    sph_host_model_i.cs_set(1'b0);
    sph_host_model_i.xfer(8'h40, rx);
    sph_host_model_i.xfer(8'h05, rx);
    sph_host_model_i.xfer(8'ha6, rx);
    sph_host_model_i.xfer(8'h85, rx);
    sph_host_model_i.xfer(8'h00, rx);
    sph_host_model_i.cs_set(1'b1);
    chk(rx, 8'h5f);
    chk({wa, 1'b0} ^ {7'h0, 1'b0}, 8'h0a);
    chk(wd, 8'ha6);
  endtask
  task t_hdr48;
    sph_host_model_i.cs_set(1'b0);
    sph_host_model_i.xfer(8'h48, rx);
    sph_host_model_i.xfer(8'h8a, rx);
    sph_host_model_i.xfer(8'h8b, rx);
    chk(rx, 8'h50);
    sph_host_model_i.xfer(8'h0c, rx);
    chk(rx, 8'h51);
    sph_host_model_i.xfer(8'h33, rx);
    sph_host_model_i.cs_set(1'b1);
    chk({1'b0, wa}, 8'h0c);
    chk(wd, 8'h33);
  endtask
  task t_hdr43;
    s_w = nw;
    s_f = nf;
    sph_host_model_i.cs_set(1'b0);
    sph_host_model_i.xfer(8'h43, rx);
    sph_host_model_i.xfer(8'h03, rx);
    sph_host_model_i.xfer(8'h11, rx);
    sph_host_model_i.xfer(8'h22, rx);
    sph_host_model_i.xfer(8'h33, rx);
    sph_host_model_i.cs_set(1'b1);
    chk(nw - s_w, 8'h03);
    chk(nf - s_f, 8'h03);
    chk(wd, 8'h33);
  endtask
  task t_hdr41;
    s_w = nw;
    s_f = nf;
    sph_host_model_i.cs_set(1'b0);
    sph_host_model_i.xfer(8'h41, rx);
    sph_host_model_i.xfer(8'h90, rx);
    sph_host_model_i.xfer(8'h00, rx);
    chk(rx, 8'h4a);
    sph_host_model_i.xfer(8'h20, rx);
    sph_host_model_i.xfer(8'haa, rx);
    sph_host_model_i.xfer(8'hbb, rx);
    sph_host_model_i.cs_set(1'b1);
    chk(nw - s_w, 8'h02);
    chk(nf - s_f, 8'h00);
    chk({1'b0, wa}, 8'h20);
  endtask
  task t_hdr49;
    s_w = nw;
    sph_host_model_i.cs_set(1'b0);
    sph_host_model_i.xfer(8'h49, rx);
    sph_host_model_i.xfer(8'h8c, rx);
    sph_host_model_i.xfer(8'h21, rx);
    chk(rx, 8'h56);
    sph_host_model_i.xfer(8'h44, rx);
    sph_host_model_i.xfer(8'h55, rx);
    sph_host_model_i.cs_set(1'b1);
    chk(nw - s_w, 8'h02);
    chk({1'b0, wa}, 8'h21);
    chk(wd, 8'h55);
  endtask
  task t_burst_rd;
    s_f = nf;
    sph_host_model_i.cs_set(1'b0);
    sph_host_model_i.xfer(8'h43, rx);
    sph_host_model_i.xfer(8'h84, rx);
    sph_host_model_i.xfer(8'hff, rx);
    chk(rx, 8'h5e);
    sph_host_model_i.xfer(8'hff, rx);
    chk(rx, 8'h5e);
    sph_host_model_i.cs_set(1'b1);
    chk(nf - s_f, 8'h02);
  endtask
  // unknown header and out-of-range burst are dropped until chip select rises
  task t_refuse;
    s_w = nw;
    sph_host_model_i.cs_set(1'b0);
    sph_host_model_i.xfer(8'h42, rx);
    sph_host_model_i.xfer(8'h05, rx);
    sph_host_model_i.xfer(8'h99, rx);
    sph_host_model_i.cs_set(1'b1);
    chk(nw - s_w, 8'h00);
    sph_host_model_i.cs_set(1'b0);
    sph_host_model_i.xfer(8'h43, rx);
    sph_host_model_i.xfer(8'h7e, rx);
    sph_host_model_i.xfer(8'h11, rx);
    sph_host_model_i.cs_set(1'b1);
    chk(nw - s_w, 8'h00);
    sph_host_model_i.cs_set(1'b0);
    sph_host_model_i.xfer(8'h40, rx);
    sph_host_model_i.xfer(8'h7e, rx);
    sph_host_model_i.xfer(8'h12, rx);
    sph_host_model_i.cs_set(1'b1);
    chk(nw - s_w, 8'h01);
    chk(wd, 8'h12);
  endtask
  // indirect: holder then data window reaches the target
  task t_parallel;
    sph_host_model_i.par(1'b1, 7'h00, 8'h22, q);
    sph_host_model_i.par(1'b1, 7'h01, 8'h77, q);
    chk({1'b0, wa}, 8'h22);
    chk(wd, 8'h77);
    sph_host_model_i.par(1'b0, 7'h01, 8'hff, q);
    chk(q, 8'h78);
    sph_host_model_i.par(1'b0, 7'h7e, 8'hff, q);
    chk(q, 8'h22);
    sph_host_model_i.par(1'b1, 7'h00, 8'h3f, q);
    sph_host_model_i.par(1'b1, 7'h01, 8'h01, q);
    chk({7'h0, addr_mode_select}, 8'h01);
    sph_host_model_i.par(1'b1, 7'h15, 8'h66, q);
    chk({1'b0, wa}, 8'h15);
    chk(wd, 8'h66);
    sph_host_model_i.par(1'b0, 7'h15, 8'hff, q);
    chk(q, 8'h4f);
    chk({6'h0, mux, strb}, 8'h00);
    sph_host_model_i.ale_edge();
    chk({7'h0, mux}, 8'h01);
    sph_host_model_i.ale_edge();
    chk({7'h0, mux}, 8'h01);
    sph_host_model_i.mux_addr(7'h2a);
    sph_host_model_i.par(1'b1, 7'h7f, 8'h39, q);
    chk({1'b0, wa}, 8'h2a);
    chk(wd, 8'h39);
  endtask
  // static high ale from reset: r/w plus data strobe bus, indirect addressing
  task t_strobe;
    chk({6'h0, mux, strb}, 8'h01);
    sph_host_model_i.par(1'b1, 7'h00, 8'h30, q);
    sph_host_model_i.par(1'b1, 7'h01, 8'h5c, q);
    chk({1'b0, wa}, 8'h30);
    chk(wd, 8'h5c);
    sph_host_model_i.par(1'b0, 7'h01, 8'hff, q);
    chk(q, 8'h6a);
  endtask
  initial begin
    sph_host_model_i.wt(40000);
    n_mismatch++;
    complete_run();
  end
  initial begin
    do_reset(1'b1, 1'b0);
    t_hdr40();
    t_hdr48();
    t_hdr43();
    t_hdr41();
    t_hdr49();
    t_burst_rd();
    t_refuse();
    do_reset(1'b0, 1'b0);
    t_parallel();
    do_reset(1'b0, 1'b1);
    t_strobe();
    complete_run();
  end
endmodule
